// ==== core/vtrc_pkg.sv ====
// Package with register map, field layout and constants of the vector table and reset control
package vtrc_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] VTL_OFF = 8'h08;
  localparam logic [7:0] IRC_OFF = 8'h0c;

  // ----------------------------------------
  // Vector table location fields
  // ----------------------------------------
  localparam int SPACE_BIT = 29;
  localparam int TOFF_HI = 28;
  localparam int TOFF_LO = 7;
  localparam logic [31:0] VTL_RESET = 32'h0000_0000;
  localparam logic [31:0] SPACE_CODE_BASE = 32'h0000_0000;
  localparam logic [31:0] SPACE_SRAM_BASE = 32'h2000_0000;

  // ----------------------------------------
  // Interrupt and reset control fields
  // ----------------------------------------
  localparam logic [15:0] KEY_WRITE = 16'h05fa;
  localparam logic [15:0] KEY_READ = 16'hfa05;
  localparam int KEY_LO = 16;
  localparam int ORDER_BIT = 15;
  localparam int SPLIT_HI = 10;
  localparam int SPLIT_LO = 8;
  localparam int RSTREQ_BIT = 2;
  localparam int CLRACT_BIT = 1;
  localparam int CORERST_BIT = 0;
  localparam logic [2:0] SPLIT_RESET = 3'h0;
  localparam logic BYTE_ORDER_VAL = 1'b0;

  // ----------------------------------------
  // Priority field width
  // ----------------------------------------
  localparam int PRIO_W = 8;
endpackage

// ==== core/vtrc_prio_split.sv ====
// Splits one priority value into pre-emption and subpriority parts
`timescale 1ns/1ps
`default_nettype none
module vtrc_prio_split #(
  parameter int PRIO_W = vtrc_pkg::PRIO_W
) (
  // Grouping selection and priority value
  input wire logic [2:0] split_sel,
  input wire logic [PRIO_W-1:0] prio_in,
  // Split result, unused bits zero
  output logic [PRIO_W-1:0] preempt_out,
  output logic [PRIO_W-1:0] subprio_out
);
  logic [PRIO_W-1:0] sub_mask;

  always_comb begin
    // Code n leaves n+1 low bits to subpriority
    sub_mask = PRIO_W'((9'h2 << split_sel) - 9'h1);
    // Four-bit shift count, so code 7 shifts by 8 instead of wrapping to 0
    preempt_out = (prio_in & ~sub_mask) >> ({1'b0, split_sel} + 4'h1);
    subprio_out = prio_in & sub_mask;
  end
endmodule
`default_nettype wire

// ==== core/vtrc_pulse.sv ====
// One-shot pulse generator for self-clearing control bits
`timescale 1ns/1ps
`default_nettype none
module vtrc_pulse (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Trigger and pulse
  input wire logic trig,
  output logic pulse_q
);
  logic pulse_d;

  always_comb begin
    pulse_d = trig;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end
endmodule
`default_nettype wire

// ==== core/vtrc_top.sv ====
// Vector table location and keyed interrupt and reset control registers
// ----------------------------------------
// How it works
// - Bit 29 selects code space (0) or SRAM space (1) for the table.
// - Bits 28..7 hold the table offset from the selected space start.
// - Control register reads return 0xfa05 in the key field.
// - Bit 15 shows byte order: 1 big-endian, 0 little-endian.
// - Bits 10..8 choose the pre-emption versus subpriority split.
// - The chosen split applies to every interrupt priority field.
// - Writing 1 to clear-active erases all active state, then self-clears.
// - Writing 1 to core reset resets the system, then reads zero.
// - Reset request drives the request output until warm reset or a keyed write with bit 2 at 0 clears it.
// - Byte order is fixed little-endian, so bit 15 reads 0.
// ----------------------------------------
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vtrc_top #(
  parameter int PRIO_W = vtrc_pkg::PRIO_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Vector table placement
  output logic [31:0] table_base_addr,
  // Priority split service for the arbiter
  input wire logic [PRIO_W-1:0] prio_in,
  output logic [PRIO_W-1:0] preempt_out,
  output logic [PRIO_W-1:0] subprio_out,
  output logic [2:0] priority_split_select,
  // System control outputs
  output logic byte_order_bit,
  output logic clear_active_pulse,
  output logic core_reset_pulse,
  output logic reset_request_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic table_space_select_q, table_space_select_d;
  logic [21:0] table_offset_field_q, table_offset_field_d;
  logic [2:0] split_q, split_d;
  logic rstreq_q, rstreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_vtl, wr_irc, key_ok;
  logic clr_trig, core_trig;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  always_comb begin
    wr_vtl = reg_wr && (reg_addr == vtrc_pkg::VTL_OFF);
    key_ok = (reg_wdata[31:vtrc_pkg::KEY_LO] == vtrc_pkg::KEY_WRITE);
    wr_irc = reg_wr && (reg_addr == vtrc_pkg::IRC_OFF) && key_ok;
    clr_trig = wr_irc && reg_wdata[vtrc_pkg::CLRACT_BIT];
    core_trig = wr_irc && reg_wdata[vtrc_pkg::CORERST_BIT];
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    table_space_select_d = table_space_select_q;
    table_offset_field_d = table_offset_field_q;
    split_d = split_q;
    rstreq_d = rstreq_q;
    if (wr_vtl) begin
      table_space_select_d = reg_wdata[vtrc_pkg::SPACE_BIT];
      table_offset_field_d = reg_wdata[vtrc_pkg::TOFF_HI:vtrc_pkg::TOFF_LO];
    end
    if (wr_irc) begin
      split_d = reg_wdata[vtrc_pkg::SPLIT_HI:vtrc_pkg::SPLIT_LO];
      rstreq_d = reg_wdata[vtrc_pkg::RSTREQ_BIT];
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        vtrc_pkg::VTL_OFF: begin
          rdata_d[vtrc_pkg::SPACE_BIT] = table_space_select_q;
          rdata_d[vtrc_pkg::TOFF_HI:vtrc_pkg::TOFF_LO] = table_offset_field_q;
        end
        vtrc_pkg::IRC_OFF: begin
          rdata_d[31:vtrc_pkg::KEY_LO] = vtrc_pkg::KEY_READ;
          rdata_d[vtrc_pkg::ORDER_BIT] = vtrc_pkg::BYTE_ORDER_VAL;
          rdata_d[vtrc_pkg::SPLIT_HI:vtrc_pkg::SPLIT_LO] = split_q;
          rdata_d[vtrc_pkg::RSTREQ_BIT] = rstreq_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset request is cleared by the warm reset it causes, which arrives on srst
  always_ff @(posedge mclk) begin
    if (srst) begin
      table_space_select_q <= vtrc_pkg::VTL_RESET[vtrc_pkg::SPACE_BIT];
      table_offset_field_q <= vtrc_pkg::VTL_RESET[vtrc_pkg::TOFF_HI:vtrc_pkg::TOFF_LO];
      split_q <= vtrc_pkg::SPLIT_RESET;
      rstreq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      table_space_select_q <= table_space_select_d;
      table_offset_field_q <= table_offset_field_d;
      split_q <= split_d;
      rstreq_q <= rstreq_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Self-clearing pulses
  // ----------------------------------------
  // The stored bit never exists, so the bits read zero right after the write
  vtrc_pulse u_clr (
    .mclk(mclk),
    .srst(srst),
    .trig(clr_trig),
    .pulse_q(clear_active_pulse)
  );

  vtrc_pulse u_core (
    .mclk(mclk),
    .srst(srst),
    .trig(core_trig),
    .pulse_q(core_reset_pulse)
  );

  // ----------------------------------------
  // Priority split
  // ----------------------------------------
  vtrc_prio_split #(
    .PRIO_W(PRIO_W)
  ) u_split (
    .split_sel(split_q),
    .prio_in(prio_in),
    .preempt_out(preempt_out),
    .subprio_out(subprio_out)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Offset alignment is left to software; low bits are never stored
  always_comb begin
    table_base_addr = (table_space_select_q ? vtrc_pkg::SPACE_SRAM_BASE
                       : vtrc_pkg::SPACE_CODE_BASE)
                      | {3'h0, table_offset_field_q, 7'h00};
    reg_rdata = rdata_q;
    priority_split_select = split_q;
    byte_order_bit = vtrc_pkg::BYTE_ORDER_VAL;
    reset_request_out = rstreq_q;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Own view of the bus, so a broken key decode cannot hide from the checks
  logic chk_irc_wr, chk_key_match;
  always_comb begin
    chk_irc_wr = reg_wr && (reg_addr == vtrc_pkg::IRC_OFF);
    chk_key_match = (reg_wdata[31:vtrc_pkg::KEY_LO] == vtrc_pkg::KEY_WRITE);
  end

  property p_bad_key_keeps;
    @(posedge mclk) disable iff (srst)
    (chk_irc_wr && !chk_key_match)
    |=> $stable(split_q) && $stable(rstreq_q) && !clear_active_pulse && !core_reset_pulse;
  endproperty
  a_bad_key_keeps: assert property (p_bad_key_keeps) else $error("bad key changed register");

  property p_key_read;
    @(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == vtrc_pkg::IRC_OFF) |=> reg_rdata[31:16] == 16'hfa05 && !reg_rdata[15];
  endproperty
  a_key_read: assert property (p_key_read) else $error("key readback wrong");

  property p_clr_self;
    @(posedge mclk) disable iff (srst)
    clr_trig |=> clear_active_pulse ##1 (!clear_active_pulse || $past(clr_trig));
  endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear active not one shot");

  property p_core_pulse;
    @(posedge mclk) disable iff (srst)
    core_trig |=> core_reset_pulse;
  endproperty
  a_core_pulse: assert property (p_core_pulse) else $error("core reset missing");

  property p_rstreq;
    @(posedge mclk) disable iff (srst)
    (chk_irc_wr && chk_key_match && reg_wdata[vtrc_pkg::RSTREQ_BIT]) |=> reset_request_out;
  endproperty
  a_rstreq: assert property (p_rstreq) else $error("reset request not raised");

  property p_space;
    @(posedge mclk) disable iff (srst)
    wr_vtl |=> table_base_addr[29] == $past(reg_wdata[29])
               && table_base_addr[28:7] == $past(reg_wdata[28:7]);
  endproperty
  a_space: assert property (p_space) else $error("table placement wrong");

  property p_split;
    @(posedge mclk) disable iff (srst)
    (split_q == 3'h7) |-> preempt_out == 8'h00 && subprio_out == prio_in;
  endproperty
  a_split: assert property (p_split) else $error("split code 7 wrong");

  property p_unused;
    @(posedge mclk) disable iff (srst)
    $past(reg_rd) && $past(reg_addr) == vtrc_pkg::VTL_OFF |-> reg_rdata[31:30] == 2'h0
                                                         && reg_rdata[6:0] == 7'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero");

  property p_order;
    @(posedge mclk) disable iff (srst)
    !byte_order_bit;
  endproperty
  a_order: assert property (p_order) else $error("byte order not little");

  property p_core_self;
    @(posedge mclk) disable iff (srst)
    core_trig |=> core_reset_pulse ##1 (!core_reset_pulse || $past(core_trig));
  endproperty
  a_core_self: assert property (p_core_self) else $error("core reset too long");

  property p_rstreq_clear;
    @(posedge mclk) disable iff (srst)
    (chk_irc_wr && chk_key_match && !reg_wdata[vtrc_pkg::RSTREQ_BIT]) |=> !reset_request_out;
  endproperty
  a_rstreq_clear: assert property (p_rstreq_clear) else $error("request kept");

  property p_split_store;
    @(posedge mclk) disable iff (srst)
    (chk_irc_wr && chk_key_match)
    |=> priority_split_select == $past(reg_wdata[vtrc_pkg::SPLIT_HI:vtrc_pkg::SPLIT_LO]);
  endproperty
  a_split_store: assert property (p_split_store) else $error("split not stored");

  property p_split_width;
    @(posedge mclk) disable iff (srst)
    (subprio_out >> ({1'b0, priority_split_select} + 4'h1)) == '0
    && (preempt_out >> (4'h7 - {1'b0, priority_split_select})) == '0;
  endproperty
  a_split_width: assert property (p_split_width) else $error("split widths");

  property p_split_rebuild;
    @(posedge mclk) disable iff (srst)
    prio_in == (PRIO_W'(preempt_out << ({1'b0, priority_split_select} + 4'h1)) | subprio_out);
  endproperty
  a_split_rebuild: assert property (p_split_rebuild) else $error("bits lost");

  property p_table_keep;
    @(posedge mclk) disable iff (srst)
    !(reg_wr && reg_addr == vtrc_pkg::VTL_OFF) |=> $stable(table_base_addr);
  endproperty
  a_table_keep: assert property (p_table_keep) else $error("table moved");

  property p_irc_keep;
    @(posedge mclk) disable iff (srst)
    !(chk_irc_wr && chk_key_match)
    |=> $stable(priority_split_select) && $stable(reset_request_out);
  endproperty
  a_irc_keep: assert property (p_irc_keep) else $error("control changed");

  property p_rd_idle;
    @(posedge mclk) disable iff (srst)
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_unmapped_rd;
    @(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr != vtrc_pkg::VTL_OFF && reg_addr != vtrc_pkg::IRC_OFF)
    |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read");

  property p_vtl_read;
    @(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == vtrc_pkg::VTL_OFF)
    |=> reg_rdata[29:7] == $past(table_base_addr[29:7]);
  endproperty
  a_vtl_read: assert property (p_vtl_read) else $error("placement readback");

  // Self-clearing bits must read zero even right after they fire
  property p_irc_read;
    @(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == vtrc_pkg::IRC_OFF)
    |=> reg_rdata[10:8] == $past(priority_split_select)
        && reg_rdata[2] == $past(reset_request_out)
        && reg_rdata[14:11] == 4'h0 && reg_rdata[7:3] == 5'h00 && reg_rdata[1:0] == 2'h0;
  endproperty
  a_irc_read: assert property (p_irc_read) else $error("bad readback");

  c_clr: cover property (@(posedge mclk) disable iff (srst) clr_trig);
  c_core: cover property (@(posedge mclk) disable iff (srst) core_trig);
  c_sram: cover property (@(posedge mclk) disable iff (srst) table_space_select_q);
  c_rstreq: cover property (@(posedge mclk) disable iff (srst) $rose(reset_request_out));
  c_badkey: cover property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == vtrc_pkg::IRC_OFF && !key_ok);
endmodule
`default_nettype wire

// ==== verification/tb_vtrc_top.sv ====
// Self-checking testbench of the vector table and reset control registers
`timescale 1ns/1ps
`default_nettype none
module tb_vtrc_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rd;
    logic [31:0] aux;
  } vtrc_row_s;
  logic mclk;
  logic srst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] table_base_addr;
  logic [7:0] prio_in;
  logic [7:0] preempt_out;
  logic [7:0] subprio_out;
  logic [2:0] priority_split_select;
  logic byte_order_bit;
  logic clear_active_pulse;
  logic core_reset_pulse;
  logic reset_request_out;
  int bad_count;
  int n_tests;
  // Split rows change the code every time, so an ignored write cannot pass
  // Two offsets are unaligned, to show that bits 6..0 are never stored
  vtrc_row_s rows [12] = '{
    '{vtrc_pkg::VTL_OFF, 32'h2000_0080, 32'h2000_0080, 32'h2000_0080},
    '{vtrc_pkg::VTL_OFF, 32'hffff_ffff, 32'h3fff_ff80, 32'h3fff_ff80},
    '{vtrc_pkg::VTL_OFF, 32'h1fff_ff80, 32'h1fff_ff80, 32'h1fff_ff80},
    '{vtrc_pkg::VTL_OFF, 32'h0000_007f, 32'h0000_0000, 32'h0000_0000},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0100, 32'hfa05_0100, 32'h0000_2d03},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0200, 32'hfa05_0200, 32'h0000_1607},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0300, 32'hfa05_0300, 32'h0000_0b07},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0400, 32'hfa05_0400, 32'h0000_0517},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0500, 32'hfa05_0500, 32'h0000_0237},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0600, 32'hfa05_0600, 32'h0000_0137},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_0700, 32'hfa05_0700, 32'h0000_00b7},
    '{vtrc_pkg::IRC_OFF, 32'h05fa_f8f8, 32'hfa05_0000, 32'h0000_5b01}
  };

  // ----------------------------------------
  // Design
  // ----------------------------------------
  vtrc_top dut_u (
    .mclk(mclk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .table_base_addr(table_base_addr),
    .prio_in(prio_in),
    .preempt_out(preempt_out),
    .subprio_out(subprio_out),
    .priority_split_select(priority_split_select),
    .byte_order_bit(byte_order_bit),
    .clear_active_pulse(clear_active_pulse),
    .core_reset_pulse(core_reset_pulse),
    .reset_request_out(reset_request_out)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // Ends one step past the taking edge, where the pulses stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk32("reg_rdata", exp, reg_rdata);
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The whole run needs about 120 cycles; far beyond that it hangs
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    prio_in = 8'hb7;
    bad_count = 0;
    n_tests = 0;
    do_reset();
    chk1("byte_order_bit", 1'b0, byte_order_bit);
    chk32("table_base_addr", 32'h0, table_base_addr);
    rd(vtrc_pkg::VTL_OFF, 32'h0000_0000);
    rd(vtrc_pkg::IRC_OFF, 32'hfa05_0000);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rd);
      if (rows[i].addr == vtrc_pkg::VTL_OFF) begin
        chk32("table_base_addr", rows[i].aux, table_base_addr);
      end else begin
        chk32("split", rows[i].aux, {16'h0, preempt_out, subprio_out});
        chk32("split_select", 32'(rows[i].wdata[10:8]), 32'(priority_split_select));
      end
    end
    wr(vtrc_pkg::IRC_OFF, 32'h05fa_0001);
    chk1("core_reset_pulse", 1'b1, core_reset_pulse);
    chk1("clear_active_pulse", 1'b0, clear_active_pulse);
    @(posedge mclk);
    #1;
    chk1("core_reset_pulse", 1'b0, core_reset_pulse);
    wr(vtrc_pkg::IRC_OFF, 32'h05fa_0002);
    chk1("clear_active_pulse", 1'b1, clear_active_pulse);
    chk1("core_reset_pulse", 1'b0, core_reset_pulse);
    @(posedge mclk);
    #1;
    chk1("clear_active_pulse", 1'b0, clear_active_pulse);
    rd(vtrc_pkg::IRC_OFF, 32'hfa05_0000);
    wr(vtrc_pkg::IRC_OFF, 32'h05fa_0304);
    chk1("reset_request_out", 1'b1, reset_request_out);
    // Wrong keys, one of them the read-back key, must change nothing
    wr(vtrc_pkg::IRC_OFF, 32'h05fb_0703);
    chk1("core_reset_pulse", 1'b0, core_reset_pulse);
    wr(vtrc_pkg::IRC_OFF, 32'hfa05_0500);
    rd(vtrc_pkg::IRC_OFF, 32'hfa05_0304);
    @(posedge mclk);
    #1;
    chk32("reg_rdata", 32'h0, reg_rdata);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0000_0000);
    rd(vtrc_pkg::VTL_OFF, 32'h0000_0000);
    // Placement set before the mid-run reset, so the reset has something to clear
    wr(vtrc_pkg::VTL_OFF, 32'h2000_0080);
    chk32("table_base_addr", 32'h2000_0080, table_base_addr);
    do_reset();
    chk1("reset_request_out", 1'b0, reset_request_out);
    chk32("table_base_addr", 32'h0, table_base_addr);
    rd(vtrc_pkg::IRC_OFF, 32'hfa05_0000);
    rd(vtrc_pkg::VTL_OFF, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
